// ===== hw/serial_ctl_pkg.sv
// Constants, register layout and carrier types for the serial control register block
package serial_ctl_pkg;

  localparam int ADDR_W = 8;
  localparam int REG_W = 16;
  localparam int DIV_W = 9;

  // Register byte offsets
  localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h08;

  // Reset values
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;

  // Status field positions
  localparam int STAT_BUSY_POS = 7;
  localparam int STAT_FAULT_POS = 5;
  localparam int STAT_SELECT_POS = 8;
  localparam int STAT_LSB_POS = 9;

  // Clock divider constants
  localparam logic [8:0] DIV_BASE = 9'h002;

  // Control register one, bit 15 down to bit 0
  typedef struct packed {
    logic single_wire_select;
    logic single_wire_output_enable;
    logic crc_enable;
    logic crc_send_next;
    logic frame_width_select;
    logic receive_only_select;
    logic select_software_manage;
    logic internal_select_level;
    logic low_bit_first;
    logic interface_enable;
    logic [2:0] baud_divisor_code;
    logic master_role;
    logic clock_idle_level;
    logic clock_sample_edge;
  } ctrl_one_t;

  // Software register port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ===== hw/serial_ctl.sv
// Serial interface control register one with clock divider, select and mode fault logic
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module serial_ctl #(
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire serial_ctl_pkg::reg_req_t req,
  output logic [15:0] rdata,
  input wire logic busy,
  input wire logic high_speed_receive_enable,
  input wire logic slave_select_pin,
  input wire logic crc_word_sent,
  output serial_ctl_pkg::ctrl_one_t cfg,
  output logic crc_reset,
  output logic low_bit_first_eff,
  output logic select_level_eff,
  output logic data_line_oe,
  output logic receive_path_enable,
  output logic sck_o,
  output logic sck_oe,
  output logic mode_fault_flag
);

  // Width check at elaboration
  if (DATA_W != 16) begin : g_width_check
    $error("serial_ctl supports DATA_W of 16 only");
  end

  typedef struct packed {
    serial_ctl_pkg::ctrl_one_t ctrl;
    logic fault;
    logic clear_armed;
    logic crc_clear_pulse;
    logic [serial_ctl_pkg::DIV_W-1:0] cnt;
    logic sck;
    logic [15:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic wr_ctrl;
  logic rd_stat;
  logic rd_ctrl;
  logic sck_run;
  logic fault_now;
  logic [serial_ctl_pkg::DIV_W-1:0] div;
  logic [serial_ctl_pkg::DIV_W-1:0] half;
  serial_ctl_pkg::ctrl_one_t wr_val;

  // Address decode
  assign wr_ctrl = req.wr && (req.addr == serial_ctl_pkg::CTRL_ONE_OFFSET);
  assign rd_ctrl = req.rd && (req.addr == serial_ctl_pkg::CTRL_ONE_OFFSET);
  assign rd_stat = req.rd && (req.addr == serial_ctl_pkg::CTRL_STATUS_OFFSET);
  assign wr_val = serial_ctl_pkg::ctrl_one_t'(req.wdata);

  // Divisor from baud code
  always_comb begin
    if (high_speed_receive_enable) begin
      div = serial_ctl_pkg::DIV_BASE + {6'h00, state_reg.ctrl.baud_divisor_code};
    end else begin
      div = serial_ctl_pkg::DIV_BASE << state_reg.ctrl.baud_divisor_code;
    end
    half = div >> 1;
  end

  // Select level and effective options
  always_comb begin
    if (state_reg.ctrl.select_software_manage) begin
      select_level_eff = state_reg.ctrl.internal_select_level;
    end else begin
      select_level_eff = slave_select_pin;
    end
    low_bit_first_eff = state_reg.ctrl.low_bit_first && state_reg.ctrl.master_role;
    fault_now = state_reg.ctrl.master_role && state_reg.ctrl.interface_enable && !select_level_eff;
    sck_run = state_reg.ctrl.master_role && state_reg.ctrl.interface_enable && busy;
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.crc_clear_pulse = 1'b0;
    state_next.rdata = 16'h0000;
    // Control register write with protected fields
    if (wr_ctrl) begin
      state_next.ctrl.single_wire_select = wr_val.single_wire_select;
      state_next.ctrl.single_wire_output_enable = wr_val.single_wire_output_enable;
      state_next.ctrl.receive_only_select = wr_val.receive_only_select;
      state_next.ctrl.select_software_manage = wr_val.select_software_manage;
      state_next.ctrl.internal_select_level = wr_val.internal_select_level;
      state_next.ctrl.interface_enable = wr_val.interface_enable;
      state_next.ctrl.baud_divisor_code = wr_val.baud_divisor_code;
      state_next.ctrl.crc_send_next = wr_val.crc_send_next;
      if (!state_reg.ctrl.interface_enable) begin
        state_next.ctrl.crc_enable = wr_val.crc_enable;
        state_next.ctrl.frame_width_select = wr_val.frame_width_select;
        state_next.crc_clear_pulse = wr_val.crc_enable && !state_reg.ctrl.crc_enable;
      end
      if (!busy) begin
        state_next.ctrl.low_bit_first = wr_val.low_bit_first;
        state_next.ctrl.master_role = wr_val.master_role;
        state_next.ctrl.clock_idle_level = wr_val.clock_idle_level;
        state_next.ctrl.clock_sample_edge = wr_val.clock_sample_edge;
      end
    end else if (crc_word_sent) begin
      state_next.ctrl.crc_send_next = 1'b0;
    end
    // Fault clear sequence: status read, then control write
    if (rd_stat) begin
      state_next.clear_armed = 1'b1;
    end else if (wr_ctrl) begin
      state_next.clear_armed = 1'b0;
    end
    if (wr_ctrl && state_reg.clear_armed) begin
      state_next.fault = 1'b0;
    end
    // Fault sets over clear and drops master and enable
    if (fault_now) begin
      state_next.fault = 1'b1;
      state_next.ctrl.interface_enable = 1'b0;
      state_next.ctrl.master_role = 1'b0;
    end
    // Serial clock divider
    if (sck_run) begin
      state_next.cnt = (state_reg.cnt >= div - 9'h001) ? 9'h000 : state_reg.cnt + 9'h001;
      state_next.sck = state_reg.ctrl.clock_idle_level ^ (state_next.cnt >= half);
    end else begin
      state_next.cnt = 9'h000;
      state_next.sck = state_next.ctrl.clock_idle_level;
    end
    // Read data one cycle after strobe
    if (rd_ctrl) begin
      state_next.rdata = state_reg.ctrl;
    end else if (rd_stat) begin
      state_next.rdata[serial_ctl_pkg::STAT_BUSY_POS] = busy;
      state_next.rdata[serial_ctl_pkg::STAT_FAULT_POS] = state_reg.fault;
      state_next.rdata[serial_ctl_pkg::STAT_SELECT_POS] = select_level_eff;
      state_next.rdata[serial_ctl_pkg::STAT_LSB_POS] = low_bit_first_eff;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign cfg = state_reg.ctrl;
  assign rdata = state_reg.rdata;
  assign crc_reset = state_reg.crc_clear_pulse;
  assign mode_fault_flag = state_reg.fault;
  assign sck_o = state_reg.sck;
  assign sck_oe = state_reg.ctrl.master_role && state_reg.ctrl.interface_enable;

  // Data line direction
  always_comb begin
    if (!state_reg.ctrl.interface_enable) begin
      data_line_oe = 1'b0;
      receive_path_enable = 1'b0;
    end else if (state_reg.ctrl.single_wire_select) begin
      data_line_oe = state_reg.ctrl.single_wire_output_enable;
      receive_path_enable = !state_reg.ctrl.single_wire_output_enable;
    end else begin
      data_line_oe = !state_reg.ctrl.receive_only_select;
      receive_path_enable = 1'b1;
    end
  end

  // Checks
  AST_CRC_EN_LOCKED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.interface_enable |=> $stable(state_reg.ctrl.crc_enable))
    else $error("crc enable changed while enabled");
  AST_WIDTH_LOCKED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.interface_enable |=> $stable(state_reg.ctrl.frame_width_select))
    else $error("frame width changed while enabled");
  AST_ROLE_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy && !fault_now |=> $stable(state_reg.ctrl.master_role))
    else $error("role changed during transfer");
  AST_ORDER_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy |=> $stable(state_reg.ctrl.low_bit_first))
    else $error("bit order changed during transfer");
  AST_SLAVE_MSB: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !state_reg.ctrl.master_role |-> !low_bit_first_eff)
    else $error("slave uses low bit first");
  AST_IDLE_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !busy ##1 !busy |-> sck_o == state_reg.ctrl.clock_idle_level)
    else $error("serial clock not at idle level");
  AST_FAULT_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fault_now |=> mode_fault_flag && !state_reg.ctrl.interface_enable)
    else $error("mode fault not flagged");
  AST_SINGLE_DIR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.interface_enable && state_reg.ctrl.single_wire_select
    |-> data_line_oe != receive_path_enable)
    else $error("single-wire direction wrong");
  AST_FAST_DIV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    high_speed_receive_enable && state_reg.ctrl.baud_divisor_code == 3'h0 && sck_run
    && state_reg.cnt == 9'h001 |=> state_reg.cnt == 9'h000)
    else $error("fast divisor not two");
  AST_READ_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !req.rd |=> rdata == 16'h0000)
    else $error("read data outside its cycle");

  // Further guards on writes, pulses, directions and the divider
  AST_CRC_PULSE_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    crc_reset |=> !crc_reset)
    else $error("crc reset pulse too long");

  AST_CRC_PULSE_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    crc_reset |-> state_reg.ctrl.crc_enable && !$past(state_reg.ctrl.crc_enable))
    else $error("crc reset without enable rising");

  AST_CRC_NEXT_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    crc_word_sent && !wr_ctrl |=> !state_reg.ctrl.crc_send_next)
    else $error("crc next not cleared after word");

  AST_MODE_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_ctrl |=> state_reg.ctrl.single_wire_select == $past(wr_val.single_wire_select))
    else $error("wire mode write lost");

  AST_ENABLE_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_ctrl && !fault_now |=> state_reg.ctrl.interface_enable == $past(wr_val.interface_enable))
    else $error("enable write lost");

  AST_DISABLED_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !state_reg.ctrl.interface_enable |-> !data_line_oe && !receive_path_enable && !sck_oe)
    else $error("pins driven while disabled");

  AST_TWO_LINE_DIR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.interface_enable && !state_reg.ctrl.single_wire_select
    |-> receive_path_enable && (data_line_oe == !state_reg.ctrl.receive_only_select))
    else $error("two-line direction wrong");

  AST_SOFT_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.select_software_manage |-> select_level_eff == state_reg.ctrl.internal_select_level)
    else $error("software select level wrong");

  AST_PIN_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !state_reg.ctrl.select_software_manage |-> select_level_eff == slave_select_pin)
    else $error("pin select level wrong");

  AST_POLARITY_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy |=> $stable(state_reg.ctrl.clock_idle_level))
    else $error("polarity changed during transfer");

  AST_PHASE_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy |=> $stable(state_reg.ctrl.clock_sample_edge))
    else $error("phase changed during transfer");

  AST_SLOW_DIV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !high_speed_receive_enable && state_reg.ctrl.baud_divisor_code == 3'h0 && sck_run
    && state_reg.cnt == 9'h001 |=> state_reg.cnt == 9'h000)
    else $error("slow divisor not two");

  AST_FAULT_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_fault_flag && !(wr_ctrl && state_reg.clear_armed) |=> mode_fault_flag)
    else $error("mode fault dropped without clear");

  AST_SCK_STOP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !sck_run |=> state_reg.cnt == 9'h000)
    else $error("divider ran outside a transfer");

  AST_READ_CTRL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_ctrl |=> rdata == $past(state_reg.ctrl))
    else $error("control read data wrong");

  AST_STATUS_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_stat |=> rdata[serial_ctl_pkg::STAT_BUSY_POS] == $past(busy))
    else $error("status busy bit wrong");

  // Main scenarios
  COV_FAULT: cover property (@(posedge sys_clk) disable iff (!rst_b) fault_now);
  COV_SINGLE_OUT: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.single_wire_select && data_line_oe);
  COV_FAST: cover property (@(posedge sys_clk) disable iff (!rst_b) high_speed_receive_enable && sck_run);
  COV_RUN: cover property (@(posedge sys_clk) disable iff (!rst_b) sck_run ##1 $changed(sck_o));
  COV_CRC_NEXT: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg.ctrl.crc_send_next ##1 crc_word_sent);

endmodule // serial_ctl
`default_nettype wire

// ===== tb/spi_far_end.sv
// Far-side device model: select pin with pull-up, serial clock period monitor
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input wire logic sck,
  input wire logic sck_oe,
  input wire logic select_now,
  output logic sel_pin,
  output var real period
);
  real last = 0.0;
  // Pin idles high through its pull-up, pulled low on request
  assign sel_pin = select_now ? 1'b0 : 1'b1;
  // Time between rising edges while the master drives the clock
  always @(posedge sck) begin
    if (sck_oe) begin
      period = $realtime - last;
    end
    last = $realtime;
  end
endmodule // spi_far_end
`default_nettype wire

// ===== tb/serial_ctl_bench.sv
// Self-checking bench for serial control register one
`timescale 1ns/1ps
`default_nettype none
module serial_ctl_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  serial_ctl_pkg::reg_req_t req = '0;
  serial_ctl_pkg::ctrl_one_t cfg;
  logic [15:0] rdata;
  logic busy = 1'b0;
  logic hs = 1'b0;
  logic crc_sent = 1'b0;
  logic pull_low = 1'b0;
  logic sel_pin, crc_reset, lbf, sel_eff, oe, rx_en, sck, sck_oe, fault;
  real period;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // Clock and hang guard
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  serial_ctl DUT (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .busy(busy),
    .high_speed_receive_enable(hs), .slave_select_pin(sel_pin), .crc_word_sent(crc_sent),
    .cfg(cfg), .crc_reset(crc_reset), .low_bit_first_eff(lbf), .select_level_eff(sel_eff),
    .data_line_oe(oe), .receive_path_enable(rx_en), .sck_o(sck), .sck_oe(sck_oe),
    .mode_fault_flag(fault));
  spi_far_end far (.sck(sck), .sck_oe(sck_oe), .select_now(pull_low), .sel_pin(sel_pin),
    .period(period));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles, entered and left 1 ns after a rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic t_regs;
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h04, 16'h0000);
    wr(8'h00, 16'h0044);
    rd_chk(8'h00, 16'h0044);
    check(cfg, 16'h0044);
    check(16'(sck_oe), 16'h0001);
    wr(8'h00, 16'h2844);
    rd_chk(8'h00, 16'h0044);
    // Disable first so the locked fields accept the next write
    wr(8'h00, 16'h0000);
    wr(8'h00, 16'h3800);
    check(16'(crc_reset), 16'h0001);
    rd_chk(8'h00, 16'h3800);
    crc_sent <= 1'b1;
    @(posedge sys_clk);
    crc_sent <= 1'b0;
    #1;
    rd_chk(8'h00, 16'h2800);
    $display("test regs done");
  endtask
  task automatic t_modes;
    logic [15:0] w [4] = '{16'h0040, 16'h0440, 16'h8040, 16'hC040};
    logic [1:0] e [4] = '{2'b11, 2'b01, 2'b01, 2'b10};
    wr(8'h00, 16'h0080);
    check(16'(lbf), 16'h0000);
    wr(8'h00, 16'h0084);
    check(16'(lbf), 16'h0001);
    wr(8'h00, 16'h0300);
    check(16'(sel_eff), 16'h0001);
    wr(8'h00, 16'h0200);
    check(16'(sel_eff), 16'h0000);
    wr(8'h00, 16'h0000);
    check(16'(sel_eff), 16'h0001);
    check(16'({oe, rx_en}), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, w[i]);
      check(16'({oe, rx_en}), 16'(e[i]));
    end
    $display("test modes done");
  endtask
  task automatic t_clock;
    logic [2:0] c [5] = '{3'h0, 3'h2, 3'h7, 3'h3, 3'h0};
    logic h [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    int p [5] = '{2, 8, 256, 5, 2};
    for (int i = 0; i < 5; i++) begin
      hs <= h[i];
      wr(8'h00, 16'h0044 | 16'(c[i]) << 3);
      busy <= 1'b1;
      repeat (2 * p[i] + 6) @(posedge sys_clk);
      busy <= 1'b0;
      #1;
      check(16'($rtoi(period / 5.0 + 0.5)), 16'(p[i]));
    end
    hs <= 1'b0;
    wr(8'h00, 16'h0046);
    repeat (2) @(posedge sys_clk);
    #1;
    check(16'(sck), 16'h0001);
    $display("test clock done");
  endtask
  task automatic t_fault;
    wr(8'h00, 16'h0044);
    pull_low <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pull_low <= 1'b0;
    #1;
    check(16'(fault), 16'h0001);
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h08, 16'h0120);
    wr(8'h00, 16'h0000);
    check(16'(fault), 16'h0000);
    $display("test fault done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_regs();
    t_modes();
    t_clock();
    t_fault();
    test_done();
  end
endmodule // serial_ctl_bench
`default_nettype wire
